/* File: tcb_consts.svh */
// Constants for the trigger condition counter bank and its link
`ifndef TCB_CONSTS_SVH
`define TCB_CONSTS_SVH

// Link framing
`define TCB_SLOTS      8
`define TCB_SLOT_W     3
`define TCB_SLOT_LAST  3'h7
`define TCB_SLOT_FIRST 3'h0
`define TCB_LANE_W     32
`define TCB_FRAME_W    256
`define TCB_FCLK_HALF  4
`define TCB_DIV_W      8

// Condition vector layout within the frame
`define TCB_IN_BITS 117
`define TCB_N_TRG   32
`define TCB_N_DET   16
`define TCB_V_MET   0
`define TCB_V_LIVE  32
`define TCB_V_FIRE  64
`define TCB_V_DET   96
`define TCB_V_EMPTY 112
`define TCB_V_HALT  113
`define TCB_V_RUN   114
`define TCB_V_TRIG  115
`define TCB_V_RESP  116

// Counter positions in the bank
`define TCB_N_CNT  116
`define TCB_CNT_W  40
`define TCB_SEL_W  8
`define TCB_C_MET  0
`define TCB_C_LIVE 32
`define TCB_C_FIRE 64
`define TCB_C_DET  96
`define TCB_C_DEAD 112
`define TCB_C_XING 113
`define TCB_C_TRIG 114
`define TCB_C_RESP 115

// Register word indices (byte address is four times the index)
`define TCB_IDX_W      30
`define TCB_IDX_CMD    30'h0
`define TCB_IDX_FLAGS  30'h1
`define TCB_IDX_STATIC 30'h2
`define TCB_IDX_END    30'hEA

// Register bits
`define TCB_CMD_CLEAR 0
`define TCB_CMD_LATCH 1
`define TCB_CMD_DONE  2
`define TCB_FLG_READY 0
`define TCB_FLG_ERROR 1
`define TCB_FLG_OVF   2

// Extended bus control bits
`define TCB_CI_W    4
`define TCB_CC_W    3
`define TCB_CI_AS   0
`define TCB_CI_DS   1
`define TCB_CI_WR   2
`define TCB_CC_AACK 0
`define TCB_CC_DACK 1

`endif

/* File: tcb_counter_bank.sv */
// Counter bank with static capture registers and word read mux
`include "tcb_consts.svh"
`default_nettype none
module tcb_counter_bank #(
   parameter int N = `TCB_N_CNT,
   parameter int W = `TCB_CNT_W
) (
   // Clock and reset
   input  wire logic                  hclk,
   input  wire logic                  hresetn,
   // Counting control
   input  wire logic [N-1:0]          inc,
   input  wire logic                  clear,
   input  wire logic                  latch,
   // Readout
   input  wire logic [`TCB_SEL_W-1:0] rd_sel,
   output var  logic [`TCB_LANE_W-1:0] rd_word,
   output var  logic                  overflow
);
   import tcb_pkg::*;

   typedef struct packed {
      logic [N-1:0][W-1:0] count;
      logic [N-1:0][W-1:0] stat;
      logic                ovf;
   } tcb_bank_t;

   tcb_bank_t r;
   tcb_bank_t n;

   // Low or high word of one static register pair
   function automatic tcb_word_t pick(input logic [W-1:0] v, input logic hi);
      logic [2*`TCB_LANE_W-1:0] wide;
      wide = (2*`TCB_LANE_W)'(v);
      pick = hi ? wide[2*`TCB_LANE_W-1:`TCB_LANE_W] : wide[`TCB_LANE_W-1:0];
   endfunction

   always_comb begin
      n = r;
      n.ovf = 1'b0;
      for (int i = 0; i < N; i++) begin
         if (latch) begin
            n.stat[i] = r.count[i];
         end
         if (clear) begin
            n.count[i] = '0;
         end else if (inc[i]) begin
            n.count[i] = r.count[i] + 1'b1;
            if (&r.count[i]) begin
               n.ovf = 1'b1;
            end
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         r <= '0;
      end else begin
         r <= n;
      end
   end

   assign rd_word  = pick(r.stat[rd_sel[`TCB_SEL_W-1:1]], rd_sel[0]);
   assign overflow = r.ovf;

endmodule // tcb_counter_bank
`default_nettype wire

/* File: tcb_counting_end.sv */
// Counting end: link demultiplexer, counter gating and register access
`include "tcb_consts.svh"
`default_nettype none
// Overview of operation
// - Forty-bit running counters, reads never reset
// - Clear-all command zeroes every counter together
// - Add one per tick when bit and gates allow
// - Condition-met counter per trigger, run gated only
// - Condition-and-live counters gated run, tokens, pause
// - Fired-per-trigger counters gated run, tokens, pause
// - Sixteen detector-up counters, run gated only
// - Unable-to-fire counter: run gated, tokens empty or paused
// - Crossings, triggers, answers totals, run gated
// - Capture runs beside counting, never delays increments
// - Each counter maps to two fixed words
// - Latch captures all at once, sets ready
// - Host polls ready, reads, then writes done
// - Reading done clears the data-ready flag
// - Latch while ready still set raises error
// - Any counter wrap raises the overflow flag
// - Command bits: clear, latch, reading done
// - 117 bits over 32-bit lane, eight slots
// - Whole condition set crosses once per tick
// - Issuing end drives a balanced fast clock
// - Host bus extended: 32 data, 7 control
module tcb_counting_end (
   // Clock and reset
   input  wire logic   hclk,
   input  wire logic   hresetn,
   // Link from issuing end
   tcb_link_if.counter link,
   // Status
   output var  logic   bunch_tick,
   output var  logic   data_ready,
   output var  logic   count_error,
   output var  logic   count_overflow
);
   import tcb_pkg::*;

   typedef struct packed {
      logic                                     fclk_s1;
      logic                                     fclk_s2;
      logic                                     fclk_d;
      logic                                     frame_s1;
      logic                                     frame_s2;
      tcb_word_t                                lane_s1;
      tcb_word_t                                lane_s2;
      tcb_word_t                                ad_s1;
      tcb_word_t                                ad_s2;
      logic [`TCB_CI_W-1:0]                     ctl_s1;
      logic [`TCB_CI_W-1:0]                     ctl_s2;
      logic [`TCB_SLOT_W-1:0]                   slot;
      logic [`TCB_SLOTS-2:0][`TCB_LANE_W-1:0]   held;
      logic [`TCB_IN_BITS-1:0]                  cond;
      logic                                     tick;
      tcb_dbus_t                                bus;
      logic [`TCB_IDX_W-1:0]                    widx;
      logic                                     wr;
      tcb_word_t                                ad_out;
      logic                                     ad_oe;
      logic                                     aack;
      logic                                     dack;
      logic                                     cmd_clear;
      logic                                     cmd_latch;
      logic                                     cmd_done;
      logic                                     ready;
      logic                                     error;
      logic                                     ovf;
   } tcb_dev_t;

   tcb_dev_t                 r;
   tcb_dev_t                 n;
   logic [`TCB_N_CNT-1:0]    inc;
   logic                     run;
   logic                     gate;
   logic [`TCB_SEL_W-1:0]    sel;
   tcb_word_t                bank_word;
   tcb_word_t                rd_val;
   logic                     ovf_pulse;

   // Counter enables from the frame of the current tick
   always_comb begin
      run  = r.cond[`TCB_V_RUN];
      gate = run & ~r.cond[`TCB_V_EMPTY] & ~r.cond[`TCB_V_HALT];
      inc  = '0;
      if (r.tick) begin
         for (int i = 0; i < `TCB_N_TRG; i++) begin
            inc[`TCB_C_MET + i]  = run & r.cond[`TCB_V_MET + i];
            inc[`TCB_C_LIVE + i] = gate & r.cond[`TCB_V_LIVE + i];
            inc[`TCB_C_FIRE + i] = gate & r.cond[`TCB_V_FIRE + i];
         end
         for (int i = 0; i < `TCB_N_DET; i++) begin
            inc[`TCB_C_DET + i] = run & r.cond[`TCB_V_DET + i];
         end
         inc[`TCB_C_DEAD] = run & (r.cond[`TCB_V_EMPTY] | r.cond[`TCB_V_HALT]);
         inc[`TCB_C_XING] = run;
         inc[`TCB_C_TRIG] = run & r.cond[`TCB_V_TRIG];
         inc[`TCB_C_RESP] = run & r.cond[`TCB_V_RESP];
      end
   end

   // Register read data
   always_comb begin
      sel    = `TCB_SEL_W'(r.widx - `TCB_IDX_STATIC);
      rd_val = '0;
      if (r.widx == `TCB_IDX_CMD) begin
         rd_val[`TCB_CMD_CLEAR] = r.cmd_clear;
         rd_val[`TCB_CMD_LATCH] = r.cmd_latch;
         rd_val[`TCB_CMD_DONE]  = r.cmd_done;
      end else if (r.widx == `TCB_IDX_FLAGS) begin
         rd_val[`TCB_FLG_READY] = r.ready;
         rd_val[`TCB_FLG_ERROR] = r.error;
         rd_val[`TCB_FLG_OVF]   = r.ovf;
      end else if (r.widx >= `TCB_IDX_STATIC && r.widx < `TCB_IDX_END) begin
         rd_val = bank_word;
      end
   end

   always_comb begin
      logic [`TCB_SLOT_W-1:0]  slot_v;
      logic [`TCB_FRAME_W-1:0] whole;
      slot_v = '0;
      whole  = '0;
      n = r;
      // Link input synchronisers
      n.fclk_s1  = link.fclk;
      n.fclk_s2  = r.fclk_s1;
      n.fclk_d   = r.fclk_s2;
      n.frame_s1 = link.frame;
      n.frame_s2 = r.frame_s1;
      n.lane_s1  = link.lane;
      n.lane_s2  = r.lane_s1;
      n.ad_s1    = link.ad;
      n.ad_s2    = r.ad_s1;
      n.ctl_s1   = link.ctl_iss;
      n.ctl_s2   = r.ctl_s1;
      // Slot demultiplexer on fast clock rising edge
      n.tick = 1'b0;
      if (r.fclk_s2 && !r.fclk_d) begin
         slot_v = r.frame_s2 ? `TCB_SLOT_FIRST : r.slot;
         if (slot_v == `TCB_SLOT_LAST) begin
            whole  = {r.lane_s2, r.held};
            n.cond = whole[`TCB_IN_BITS-1:0];
            n.tick = 1'b1;
            n.slot = `TCB_SLOT_FIRST;
         end else begin
            n.held[slot_v] = r.lane_s2;
            n.slot = slot_v + 1'b1;
         end
      end
      // Command bits act once then drop
      n.cmd_clear = 1'b0;
      n.cmd_latch = 1'b0;
      n.cmd_done  = 1'b0;
      if (r.cmd_clear) begin
         n.error = 1'b0;
         n.ovf   = 1'b0;
      end
      if (r.cmd_done) begin
         n.ready = 1'b0;
      end
      if (r.cmd_latch) begin
         n.ready = 1'b1;
         if (r.ready) begin
            n.error = 1'b1;
         end
      end
      if (ovf_pulse) begin
         n.ovf = 1'b1;
      end
      // Extended host bus slave
      case (r.bus)
         TCB_DB_IDLE: begin
            if (r.ctl_s2[`TCB_CI_AS]) begin
               n.widx = r.ad_s2[`TCB_LANE_W-1:`TCB_LANE_W-`TCB_IDX_W];
               n.wr   = r.ctl_s2[`TCB_CI_WR];
               n.aack = 1'b1;
               n.bus  = TCB_DB_ADDR;
            end
         end
         TCB_DB_ADDR: begin
            if (!r.ctl_s2[`TCB_CI_AS]) begin
               n.aack = 1'b0;
               n.bus  = TCB_DB_WAIT;
            end
         end
         TCB_DB_WAIT: begin
            if (r.ctl_s2[`TCB_CI_DS]) begin
               if (r.wr) begin
                  if (r.widx == `TCB_IDX_CMD) begin
                     n.cmd_clear = r.ad_s2[`TCB_CMD_CLEAR];
                     n.cmd_latch = r.ad_s2[`TCB_CMD_LATCH];
                     n.cmd_done  = r.ad_s2[`TCB_CMD_DONE];
                  end
               end else begin
                  n.ad_out = rd_val;
                  n.ad_oe  = 1'b1;
               end
               n.dack = 1'b1;
               n.bus  = TCB_DB_DATA;
            end
         end
         TCB_DB_DATA: begin
            if (!r.ctl_s2[`TCB_CI_DS]) begin
               n.dack  = 1'b0;
               n.ad_oe = 1'b0;
               n.bus   = TCB_DB_IDLE;
            end
         end
         default: begin
            n.bus = TCB_DB_IDLE;
         end
      endcase
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         r <= '0;
      end else begin
         r <= n;
      end
   end

   tcb_counter_bank #(
      .N (`TCB_N_CNT),
      .W (`TCB_CNT_W)
   ) u_bank (
      .hclk     (hclk),
      .hresetn  (hresetn),
      .inc      (inc),
      .clear    (r.cmd_clear),
      .latch    (r.cmd_latch),
      .rd_sel   (sel),
      .rd_word  (bank_word),
      .overflow (ovf_pulse)
   );

   // Link and status outputs
   assign link.ctl_cnt   = {1'b0, r.dack, r.aack};
   assign link.ad_cnt    = r.ad_out;
   assign link.ad_cnt_oe = r.ad_oe;
   assign bunch_tick     = r.tick;
   assign data_ready     = r.ready;
   assign count_error    = r.error;
   assign count_overflow = r.ovf;

endmodule // tcb_counting_end
`default_nettype wire

/* File: tcb_issuing_end.sv */
// Issuing end: fast clock, condition multiplexer and AHB-Lite bus extender
`include "tcb_consts.svh"
`default_nettype none
module tcb_issuing_end #(
   parameter int HALF = `TCB_FCLK_HALF
) (
   // Clock and reset
   input  wire logic                    hclk,
   input  wire logic                    hresetn,
   // Condition bits, one set per bunch tick
   input  wire logic [`TCB_IN_BITS-1:0] cond_bits,
   // AHB-Lite slave
   input  wire logic                    hsel,
   input  wire logic [31:0]             haddr,
   input  wire logic [1:0]              htrans,
   input  wire logic                    hwrite,
   input  wire logic [2:0]              hsize,
   input  wire logic [31:0]             hwdata,
   input  wire logic                    hready,
   output var  logic [31:0]             hrdata,
   output var  logic                    hreadyout,
   output var  logic                    hresp,
   // Link to counting end
   tcb_link_if.issuer                   link
);
   import tcb_pkg::*;

   typedef struct packed {
      logic [`TCB_DIV_W-1:0]                  div;
      logic                                   fclk;
      logic [`TCB_SLOT_W-1:0]                 slot;
      logic [`TCB_SLOTS-1:0][`TCB_LANE_W-1:0] vec;
      tcb_word_t                              lane;
      logic                                   frame;
      logic [`TCB_CC_W-1:0]                   ctl_s1;
      logic [`TCB_CC_W-1:0]                   ctl_s2;
      tcb_word_t                              ad_s1;
      tcb_word_t                              ad_s2;
      tcb_ibus_t                              bus;
      logic                                   wr;
      tcb_word_t                              ad_out;
      logic                                   ad_oe;
      logic                                   as;
      logic                                   ds;
      logic                                   rdy_n;
      tcb_word_t                              rdata;
   } tcb_iss_t;

   tcb_iss_t r;
   tcb_iss_t n;

   always_comb begin
      logic [`TCB_SLOT_W-1:0] nslot;
      nslot = '0;
      n = r;
      n.ctl_s1 = link.ctl_cnt;
      n.ctl_s2 = r.ctl_s1;
      n.ad_s1  = link.ad;
      n.ad_s2  = r.ad_s1;
      // Fast clock divider; lane changes on falling edge
      if (r.div == `TCB_DIV_W'(HALF - 1)) begin
         n.div  = '0;
         n.fclk = ~r.fclk;
         if (r.fclk) begin
            if (r.slot == `TCB_SLOT_LAST) begin
               nslot = `TCB_SLOT_FIRST;
               n.vec = `TCB_FRAME_W'(cond_bits);
            end else begin
               nslot = r.slot + 1'b1;
            end
            n.slot  = nslot;
            n.lane  = n.vec[nslot];
            n.frame = (nslot == `TCB_SLOT_FIRST);
         end
      end else begin
         n.div = r.div + 1'b1;
      end
      // Bus extender
      case (r.bus)
         TCB_IB_IDLE: begin
            if (hsel && htrans[1] && hready) begin
               n.wr     = hwrite;
               n.ad_out = haddr;
               n.ad_oe  = 1'b1;
               n.as     = 1'b1;
               n.rdy_n  = 1'b1;
               n.bus    = TCB_IB_ADDR;
            end
         end
         TCB_IB_ADDR: begin
            if (r.ctl_s2[`TCB_CC_AACK]) begin
               n.as  = 1'b0;
               n.bus = TCB_IB_AREL;
            end
         end
         TCB_IB_AREL: begin
            if (!r.ctl_s2[`TCB_CC_AACK]) begin
               n.ad_out = hwdata;
               n.ad_oe  = r.wr;
               n.ds     = 1'b1;
               n.bus    = TCB_IB_DATA;
            end
         end
         TCB_IB_DATA: begin
            if (r.ctl_s2[`TCB_CC_DACK]) begin
               n.rdata = r.ad_s2;
               n.ds    = 1'b0;
               n.bus   = TCB_IB_DREL;
            end
         end
         TCB_IB_DREL: begin
            if (!r.ctl_s2[`TCB_CC_DACK]) begin
               n.ad_oe = 1'b0;
               n.rdy_n = 1'b0;
               n.bus   = TCB_IB_IDLE;
            end
         end
         default: begin
            n.bus = TCB_IB_IDLE;
         end
      endcase
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         r <= '0;
      end else begin
         r <= n;
      end
   end

   assign link.fclk      = r.fclk;
   assign link.frame     = r.frame;
   assign link.lane      = r.lane;
   assign link.ctl_iss   = {1'b0, r.wr, r.ds, r.as};
   assign link.ad_iss    = r.ad_out;
   assign link.ad_iss_oe = r.ad_oe;
   assign hrdata         = r.rdata;
   assign hreadyout      = ~r.rdy_n;
   assign hresp          = 1'b0;

endmodule // tcb_issuing_end
`default_nettype wire

/* File: tcb_link_if.sv */
// Link between the issuing end and the counting end
`include "tcb_consts.svh"
`default_nettype none
interface tcb_link_if;
   logic                    fclk;
   logic                    frame;
   logic [`TCB_LANE_W-1:0]  lane;
   logic [`TCB_CI_W-1:0]    ctl_iss;
   logic [`TCB_CC_W-1:0]    ctl_cnt;
   logic [`TCB_LANE_W-1:0]  ad_iss;
   logic                    ad_iss_oe;
   logic [`TCB_LANE_W-1:0]  ad_cnt;
   logic                    ad_cnt_oe;
   logic [`TCB_LANE_W-1:0]  ad;

   // Shared address/data wire level
   assign ad = ad_iss_oe ? ad_iss : (ad_cnt_oe ? ad_cnt : '0);

   modport issuer (output fclk, frame, lane, ctl_iss, ad_iss, ad_iss_oe,
                   input  ctl_cnt, ad);
   modport counter (input  fclk, frame, lane, ctl_iss, ad,
                    output ctl_cnt, ad_cnt, ad_cnt_oe);
endinterface
`default_nettype wire

/* File: tcb_pkg.sv */
// Types for the trigger condition counter bank
`include "tcb_consts.svh"
`default_nettype none
package tcb_pkg;

   typedef logic [`TCB_LANE_W-1:0] tcb_word_t;

   typedef enum logic [1:0] {
      TCB_DB_IDLE = 2'h0,
      TCB_DB_ADDR = 2'h1,
      TCB_DB_WAIT = 2'h3,
      TCB_DB_DATA = 2'h2
   } tcb_dbus_t;

   typedef enum logic [2:0] {
      TCB_IB_IDLE = 3'h0,
      TCB_IB_ADDR = 3'h1,
      TCB_IB_AREL = 3'h3,
      TCB_IB_DATA = 3'h2,
      TCB_IB_DREL = 3'h6
   } tcb_ibus_t;

endpackage
`default_nettype wire

/* File: tcb_properties.sv */
// Link protocol assertions for the counter bank link
`include "tcb_consts.svh"
`default_nettype none
module tcb_properties #(
   parameter int HALF = `TCB_FCLK_HALF
) (
   // Clock and reset
   input wire logic                   hclk,
   input wire logic                   hresetn,
   // Link signals
   input wire logic                   fclk,
   input wire logic                   frame,
   input wire logic [`TCB_LANE_W-1:0] lane,
   input wire logic [`TCB_CI_W-1:0]   ctl_iss,
   input wire logic [`TCB_CC_W-1:0]   ctl_cnt,
   input wire logic                   ad_iss_oe,
   input wire logic                   ad_cnt_oe
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   // Cycles since the last frame start
   int   gap;
   logic frame_q;
   logic seen;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         gap     <= 0;
         frame_q <= 1'b0;
         seen    <= 1'b0;
      end else begin
         frame_q <= frame;
         gap     <= (frame && !frame_q) ? 0 : gap + 1;
         seen    <= seen | (frame && !frame_q);
      end
   end
   sequence s_slot0;
      frame [*8] ##1 !frame;
   endsequence
   sequence s_zero_slot;
      (lane == '0) [*8];
   endsequence
   property p_slot0_width; $rose(frame) |-> s_slot0; endproperty
   a_slot0_width: assert property (p_slot0_width) else $error("marker width wrong");
   property p_period; $rose(frame) && seen |-> gap == 16 * HALF - 1; endproperty
   a_period: assert property (p_period) else $error("frame period wrong");
   property p_upper_zero; $rose(frame) |-> ##32 s_zero_slot ##17 s_zero_slot; endproperty
   a_upper_zero: assert property (p_upper_zero) else $error("spare slot not zero");
   property p_lane_at_fall; $changed(lane) |-> $fell(fclk); endproperty
   a_lane_at_fall: assert property (p_lane_at_fall) else $error("lane moved off fall");
   property p_fclk_even; $changed(fclk) |=> $stable(fclk) [*3] ##1 $changed(fclk); endproperty
   a_fclk_even: assert property (p_fclk_even) else $error("fast clock uneven");
   property p_one_driver; !(ad_iss_oe && ad_cnt_oe); endproperty
   a_one_driver: assert property (p_one_driver) else $error("both ends drive ad");
   property p_aack; $rose(ctl_cnt[`TCB_CC_AACK]) |-> ctl_iss[`TCB_CI_AS]; endproperty
   a_aack: assert property (p_aack) else $error("ack without strobe");
   property p_rd_drive; $rose(ad_cnt_oe) |-> ctl_iss[`TCB_CI_DS] && !ctl_iss[`TCB_CI_WR];
   endproperty
   a_rd_drive: assert property (p_rd_drive) else $error("counter drives off read");
endmodule // tcb_properties
`default_nettype wire

/* File: test_trigger_condition_counter_bank.sv */
// Bench driving both link ends over AHB-Lite and condition bits
`include "tcb_consts.svh"
`default_nettype none
module test_trigger_condition_counter_bank;
   import tcb_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int NC = 10;
   localparam int IDX [NC] = '{0, 1, 31, 40, 95, 111, 112, 113, 114, 115};
   localparam logic [116:0] PAT = {3'h7, 2'h0, 16'h8000, 32'h8000_0000, 32'h100, 32'h1};
   logic                    hclk, hresetn, hsel, hwrite, hreadyout, hresp;
   logic                    bunch_tick, data_ready, count_error, count_overflow;
   logic [1:0]              htrans;
   logic [2:0]              hsize;
   logic [31:0]             haddr, hwdata, hrdata;
   logic [`TCB_IN_BITS-1:0] cond;
   logic [39:0]             exp_cnt [NC];
   int                      err_count = 0;
   int                      cmp_count = 0;
   int                      ticks = 0;

   tcb_link_if link_bus ();
   tcb_issuing_end u_tcb_issuing_end (
      .hclk(hclk), .hresetn(hresetn), .cond_bits(cond), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .link(link_bus)
   );
   tcb_counting_end u_tcb_counting_end (
      .hclk(hclk), .hresetn(hresetn), .link(link_bus), .bunch_tick(bunch_tick),
      .data_ready(data_ready), .count_error(count_error), .count_overflow(count_overflow)
   );
   tcb_properties u_tcb_properties (
      .hclk(hclk), .hresetn(hresetn), .fclk(link_bus.fclk), .frame(link_bus.frame),
      .lane(link_bus.lane), .ctl_iss(link_bus.ctl_iss), .ctl_cnt(link_bus.ctl_cnt),
      .ad_iss_oe(link_bus.ad_iss_oe), .ad_cnt_oe(link_bus.ad_cnt_oe)
   );

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] want);
      cmp_count++;
      if (seen !== want) begin
         err_count++;
         $display("unexpected %s: expected %h seen %h", what, want, seen);
      end
   endtask

   task automatic tally_and_finish();
      $display("compares %0d mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   // One single AHB-Lite transfer, entered just after a rising edge
   task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] wd,
                      output logic [31:0] rd_data);
      hsel   <= 1'b1;
      htrans <= 2'h2;
      haddr  <= a;
      hwrite <= wr;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      hsel   <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rd_data = hrdata;
      check("bus response", {31'h0, hresp}, 32'h0);
   endtask

   task automatic wr(input logic [31:0] a, input logic [31:0] wd);
      logic [31:0] d;
      bus(1'b1, a, wd, d);
   endtask

   task automatic rd(input logic [31:0] a, output logic [31:0] d);
      bus(1'b0, a, 32'h0, d);
   endtask

   // Increment expected for counter k under condition set p
   function automatic logic inc_of(input int k, input logic [116:0] p);
      logic run;
      logic open;
      run  = p[`TCB_V_RUN];
      open = run & !p[`TCB_V_EMPTY] & !p[`TCB_V_HALT];
      if (k == `TCB_C_DEAD) return run & (p[`TCB_V_EMPTY] | p[`TCB_V_HALT]);
      if (k == `TCB_C_XING) return run;
      if (k == `TCB_C_TRIG) return run & p[`TCB_V_TRIG];
      if (k == `TCB_C_RESP) return run & p[`TCB_V_RESP];
      if (k >= `TCB_C_LIVE && k < `TCB_C_DET) return open & p[k];
      return run & p[k];
   endfunction

   // Present p for exactly n bunch ticks, then idle
   task automatic run_frames(input logic [116:0] p, input int n);
      int t0;
      @(posedge link_bus.frame);
      cond <= p;
      @(posedge link_bus.frame);
      @(posedge hclk);
      t0 = ticks;
      check("lane slot 0", link_bus.lane, p[31:0]);
      repeat (n - 1) @(posedge link_bus.frame);
      cond <= '0;
      repeat (3) @(posedge link_bus.frame);
      @(posedge hclk);
      check("bunch ticks", 32'(ticks - t0), 32'(n + 2));
      for (int i = 0; i < NC; i++) exp_cnt[i] += 40'(n * inc_of(IDX[i], p));
      @(posedge hclk);
   endtask

   // Latch, poll, read the sampled counters, then hand back
   task automatic check_bank();
      logic [31:0] d;
      int          t;
      wr(32'h0, 32'h2);
      t = 0;
      do begin
         rd(32'h4, d);
         t++;
      end while (d[0] !== 1'b1 && t < 8);
      check("ready flag", d, 32'h1);
      check("ready pin", {31'h0, data_ready}, 32'h1);
      for (int i = 0; i < NC; i++) begin
         rd(32'(8 + 8 * IDX[i]), d);
         check("count low", d, exp_cnt[i][31:0]);
         rd(32'(12 + 8 * IDX[i]), d);
         check("count high", d, {24'h0, exp_cnt[i][39:32]});
      end
      wr(32'h0, 32'h4);
      rd(32'h4, d);
      check("ready cleared", d, 32'h0);
   endtask

   task automatic test_reset();
      logic [31:0] d;
      rd(32'h0, d);
      check("command reset", d, 32'h0);
      rd(32'h4, d);
      check("flags reset", d, 32'h0);
      check("overflow pin", {31'h0, count_overflow}, 32'h0);
      $display("test reset done");
   endtask

   task automatic test_counting();
      run_frames(PAT, 3);
      check_bank();
      run_frames(PAT & ~(117'h1 << `TCB_V_RUN), 2);
      check_bank();
      $display("test counting done");
   endtask

   task automatic test_blocked();
      run_frames(PAT | (117'h1 << `TCB_V_EMPTY), 2);
      check_bank();
      run_frames(PAT | (117'h1 << `TCB_V_HALT), 1);
      check_bank();
      $display("test blocked done");
   endtask

   task automatic test_error_clear();
      logic [31:0] d;
      wr(32'h0, 32'h2);
      wr(32'h0, 32'h2);
      rd(32'h4, d);
      check("ready and error", d, 32'h3);
      check("error pin", {31'h0, count_error}, 32'h1);
      wr(32'h0, 32'h4);
      rd(32'h4, d);
      check("error after done", d, 32'h2);
      wr(32'h0, 32'h1);
      rd(32'h0, d);
      check("command self clear", d, 32'h0);
      rd(32'h4, d);
      check("flags after clear", d, 32'h0);
      for (int i = 0; i < NC; i++) exp_cnt[i] = '0;
      check_bank();
      $display("test error and clear done");
   endtask

   task automatic test_unmapped();
      logic [31:0] d;
      rd(32'h3A8, d);
      check("unmapped read", d, 32'h0);
      wr(32'h4, 32'h7);
      rd(32'h4, d);
      check("flags read only", d, 32'h0);
      wr(32'h8, 32'hFFFF_FFFF);
      rd(32'h8, d);
      check("static read only", d, 32'h0);
      $display("test unmapped done");
   endtask

   initial begin
      hclk = 1'b0;
      forever #2 hclk = ~hclk;
   end

   // Received bunch ticks
   always @(posedge hclk) begin
      if (bunch_tick === 1'b1) ticks <= ticks + 1;
   end

   initial begin
      #200000;
      err_count++;
      tally_and_finish();
   end

   initial begin
      hresetn = 1'b0;
      hsel    = 1'b0;
      htrans  = 2'h0;
      haddr   = 32'h0;
      hwrite  = 1'b0;
      hsize   = 3'h2;
      hwdata  = 32'h0;
      cond    = '0;
      for (int i = 0; i < NC; i++) exp_cnt[i] = '0;
      repeat (8) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      test_reset();
      test_counting();
      test_blocked();
      test_error_clear();
      test_unmapped();
      tally_and_finish();
   end
endmodule // test_trigger_condition_counter_bank
`default_nettype wire
